/* File: src/l2rpa_defs.svh */
// l2rpa_defs.svh - constants for the level-2 read priority arbiter
`ifndef L2RPA_DEFS_SVH
`define L2RPA_DEFS_SVH

// bit position of the priority enable in the auxiliary control word
`define L2RPA_AUX_PRIO_BIT   10
// reset value of the priority enable: feature off
`define L2RPA_PRIO_RST       1'b0
// outstanding address slots per master interface
`define L2RPA_NUM_SLOTS      4

`endif

/* File: src/l2rpa_pkg.sv */
// l2rpa_pkg.sv - types for the level-2 read priority arbiter
`default_nettype none
package l2rpa_pkg;

  // class of a pending read
  typedef enum logic [1:0] {
    L2RPA_CLS_LINEFILL,
    L2RPA_CLS_STRONG,
    L2RPA_CLS_DEVICE
  } l2rpa_cls_t;

  // slot state
  typedef enum logic {
    L2RPA_SLOT_FREE,
    L2RPA_SLOT_BUSY
  } l2rpa_slot_t;

endpackage : l2rpa_pkg
`default_nettype wire

/* File: src/l2rpa_slots.sv */
// l2rpa_slots.sv - tracker of outstanding address slots
`default_nettype none
`include "l2rpa_defs.svh"

module l2rpa_slots
  import l2rpa_pkg::*;
#(
  parameter int NUM_SLOTS = `L2RPA_NUM_SLOTS
) (
  // clock and reset
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  // one slot taken / one slot returned
  input  wire logic        take_i,
  input  wire logic        release_i,
  // status
  output logic             slot_free_o,
  output logic [3:0]       busy_cnt_o
);

  // =========================================================
  // slot bookkeeping
  l2rpa_slot_t slot_r   [NUM_SLOTS];
  l2rpa_slot_t slot_nxt [NUM_SLOTS];
  logic [NUM_SLOTS-1:0] busy_vec;
  logic [NUM_SLOTS-1:0] take_sel;
  logic [NUM_SLOTS-1:0] rel_sel;

  genvar g;
  generate
    for (g = 0; g < NUM_SLOTS; g++) begin : g_slot
      assign busy_vec[g] = (slot_r[g] == L2RPA_SLOT_BUSY);
      // lowest free slot takes, lowest busy slot returns
      if (g == 0) begin : g_first
        assign take_sel[g] = take_i && !busy_vec[g];
        assign rel_sel[g]  = release_i && busy_vec[g];
      end else begin : g_rest
        assign take_sel[g] = take_i && !busy_vec[g] && (&busy_vec[g-1:0]);
        assign rel_sel[g]  = release_i && busy_vec[g] &&
                             !(|busy_vec[g-1:0]);
      end
      always_comb begin
        slot_nxt[g] = slot_r[g];
        if (take_sel[g]) begin
          slot_nxt[g] = L2RPA_SLOT_BUSY;
        end else if (rel_sel[g]) begin
          slot_nxt[g] = L2RPA_SLOT_FREE;
        end
      end
      always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
          slot_r[g] <= L2RPA_SLOT_FREE;
        end else begin
          slot_r[g] <= slot_nxt[g];
        end
      end
    end
  endgenerate

  // count of busy slots, combinational view for the arbiter
  always_comb begin
    busy_cnt_o = 4'h0;
    for (int i = 0; i < NUM_SLOTS; i++) begin
      busy_cnt_o = busy_cnt_o + {3'h0, busy_vec[i]};
    end
    slot_free_o = !(&busy_vec);
  end

endmodule : l2rpa_slots
`default_nettype wire

/* File: src/l2rpa_arbiter.sv */
// l2rpa_arbiter.sv - read request arbiter for one master interface
`default_nettype none
`include "l2rpa_defs.svh"

// What this block does
// - With the priority bit set, strongly ordered and device reads win.
// - Each master interface has exactly four shared outstanding slots.
// - A cacheable L2 miss is sent out as a linefill through a slot.
// - With priority on, a steady ordered stream holds a linefill back.
// - Reset clears the priority feature; one cycle after release it follows bit 10 again.
module l2rpa_arbiter
  import l2rpa_pkg::*;
#(
  parameter int NUM_SLOTS = `L2RPA_NUM_SLOTS,
  parameter int ADDR_W    = 32
) (
  // clock and reset
  input  wire logic              clk_sys_i,
  input  wire logic              rst_i,
  // auxiliary control word
  input  wire logic [31:0]       aux_ctrl_i,
  // strongly ordered / device read request
  input  wire logic              ord_req_i,
  input  wire logic              ord_dev_i,
  input  wire logic [ADDR_W-1:0] ord_addr_i,
  output logic                   ord_ack_o,
  // cacheable miss linefill request
  input  wire logic              miss_req_i,
  input  wire logic [ADDR_W-1:0] miss_addr_i,
  output logic                   miss_ack_o,
  // read address issue toward the L3 memory system
  output logic                   arvalid_o,
  output logic [ADDR_W-1:0]      araddr_o,
  output logic [1:0]             arclass_o,
  input  wire logic              arready_i,
  // completion of an outstanding read
  input  wire logic              rdone_i,
  // status
  output logic                   prio_en_o,
  output logic [3:0]             busy_cnt_o
);

  // =========================================================
  // priority enable capture
  // the bit is copied every cycle, so a change takes effect one
  // cycle later; reset forces it off whatever the control word says
  logic prio_r;
  logic prio_nxt;

  always_comb begin
    prio_nxt = aux_ctrl_i[`L2RPA_AUX_PRIO_BIT];
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      prio_r <= `L2RPA_PRIO_RST;
    end else begin
      prio_r <= prio_nxt;
    end
  end

  // =========================================================
  // slot tracker
  // a completion frees its slot only from the next cycle on, so a
  // full tracker costs one idle cycle before the next grant
  logic       slot_free;
  logic [3:0] busy_cnt;
  logic       take;

  l2rpa_slots #(
    .NUM_SLOTS (NUM_SLOTS)
  ) u_slots (
    .clk_sys_i   (clk_sys_i),
    .rst_i       (rst_i),
    .take_i      (take),
    .release_i   (rdone_i),
    .slot_free_o (slot_free),
    .busy_cnt_o  (busy_cnt)
  );

  // =========================================================
  // arrival order: age counters of waiting requests
  // a stamp counts the cycles its request has waited and restarts
  // once the ack shows; the larger stamp is the older request
  logic [15:0] ord_age_r,  ord_age_nxt;
  logic [15:0] miss_age_r, miss_age_nxt;

  always_comb begin
    ord_age_nxt  = '0;
    miss_age_nxt = '0;
    if (ord_req_i && !ord_ack_o) begin
      ord_age_nxt = (ord_age_r == 16'hffff) ? ord_age_r : ord_age_r + 16'h1;
    end
    if (miss_req_i && !miss_ack_o) begin
      miss_age_nxt = (miss_age_r == 16'hffff) ? miss_age_r
                                              : miss_age_r + 16'h1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ord_age_r  <= 16'h0;
      miss_age_r <= 16'h0;
    end else begin
      ord_age_r  <= ord_age_nxt;
      miss_age_r <= miss_age_nxt;
    end
  end

  // =========================================================
  // arrival order decision
  // only meaningful while both wait; equal stamps, saturated ones
  // included, fall to the miss so a linefill is never passed by a
  // read that came in during the same cycle
  logic ord_older;

  always_comb begin
    ord_older = (ord_age_r > miss_age_r);
  end

  // =========================================================
  // class of the ordered read as shown toward the L3 side
  l2rpa_cls_t ocls;

  always_comb begin
    case (ord_dev_i)
      1'b1:    ocls = L2RPA_CLS_DEVICE;
      default: ocls = L2RPA_CLS_STRONG;
    endcase
  end

  // =========================================================
  // issue stage: one read address register toward the L3 side
  logic              arvalid_r, arvalid_nxt;
  logic [ADDR_W-1:0] araddr_r,  araddr_nxt;
  logic [1:0]        arcls_r,   arcls_nxt;
  logic              ord_ack_r, ord_ack_nxt;
  logic              miss_ack_r, miss_ack_nxt;
  logic              pick_ord;
  logic              can_issue;

  // a new address may load once the stage is empty or drains now;
  // acks stall the requesters for a cycle so a request is not
  // taken twice
  // with priority on, nothing ages the miss: a steady ordered stream
  // that keeps every slot turning over starves the linefill; this is
  // the known flaw, kept on purpose, so leave the bit clear where the
  // requesters can sustain four ordered reads in flight
  always_comb begin
    can_issue = slot_free && (!arvalid_r || arready_i) &&
                !ord_ack_r && !miss_ack_r;
    if (prio_r) begin
      // ordered reads always win: a steady stream starves misses
      pick_ord = ord_req_i;
    end else if (ord_req_i && miss_req_i) begin
      pick_ord = ord_older;
    end else begin
      pick_ord = ord_req_i;
    end
    take         = 1'b0;
    arvalid_nxt  = arvalid_r && !arready_i;
    araddr_nxt   = araddr_r;
    arcls_nxt    = arcls_r;
    ord_ack_nxt  = 1'b0;
    miss_ack_nxt = 1'b0;
    if (can_issue && pick_ord) begin
      take        = 1'b1;
      arvalid_nxt = 1'b1;
      araddr_nxt  = ord_addr_i;
      arcls_nxt   = ocls;
      ord_ack_nxt = 1'b1;
    end else if (can_issue && miss_req_i) begin
      take         = 1'b1;
      arvalid_nxt  = 1'b1;
      araddr_nxt   = miss_addr_i;
      arcls_nxt    = L2RPA_CLS_LINEFILL;
      miss_ack_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      arvalid_r  <= 1'b0;
      araddr_r   <= '0;
      arcls_r    <= 2'h0;
      ord_ack_r  <= 1'b0;
      miss_ack_r <= 1'b0;
    end else begin
      arvalid_r  <= arvalid_nxt;
      araddr_r   <= araddr_nxt;
      arcls_r    <= arcls_nxt;
      ord_ack_r  <= ord_ack_nxt;
      miss_ack_r <= miss_ack_nxt;
    end
  end

  // =========================================================
  // status register
  // the count lags the tracker by one cycle; it only reports, the
  // issue decision reads the tracker directly
  logic [3:0] busy_cnt_r;

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      busy_cnt_r <= 4'h0;
    end else begin
      busy_cnt_r <= busy_cnt;
    end
  end

  // outputs straight from flip-flops
  assign arvalid_o  = arvalid_r;
  assign araddr_o   = araddr_r;
  assign arclass_o  = arcls_r;
  assign ord_ack_o  = ord_ack_r;
  assign miss_ack_o = miss_ack_r;
  assign prio_en_o  = prio_r;
  assign busy_cnt_o = busy_cnt_r;

endmodule : l2rpa_arbiter
`default_nettype wire

/* File: tb/l2rpa_arbiter_sva.sv */
// l2rpa_arbiter_sva.sv - port checker for the read arbiter
`default_nettype none
module l2rpa_arbiter_sva #(
  parameter int NUM_SLOTS = 4,
  parameter int ADDR_W    = 32
) (
  // clock, reset, control
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic [31:0]       aux_ctrl_i,
  // requests and grants
  input wire logic              ord_req_i,
  input wire logic              ord_dev_i,
  input wire logic [ADDR_W-1:0] ord_addr_i,
  input wire logic              miss_req_i,
  input wire logic [ADDR_W-1:0] miss_addr_i,
  input wire logic              ord_ack_o,
  input wire logic              miss_ack_o,
  // issue side and status
  input wire logic              arvalid_o,
  input wire logic [ADDR_W-1:0] araddr_o,
  input wire logic [1:0]        arclass_o,
  input wire logic              arready_i,
  input wire logic              prio_en_o,
  input wire logic [3:0]        busy_cnt_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ===========================
  // properties
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  sequence s_grant; ord_ack_o || miss_ack_o; endsequence
  sequence s_stall; arvalid_o && !arready_i; endsequence
  property p_rst; disable iff (1'b0)
    rst_i |=> !prio_en_o && !arvalid_o && busy_cnt_o == 4'h0; endproperty
  a_rst: assert property (p_rst) else $error("reset state wrong");
  property p_prio; !$past(rst_i) |-> prio_en_o == $past(aux_ctrl_i[10]);
  endproperty
  a_prio: assert property (p_prio) else $error("enable copy wrong");
  property p_win; prio_en_o && ord_req_i |=> !miss_ack_o; endproperty
  a_win: assert property (p_win) else $error("linefill beat ordered");
  property p_cnt; busy_cnt_o <= NUM_SLOTS; endproperty
  a_cnt: assert property (p_cnt) else $error("too many slots");
  property p_fill; miss_ack_o |-> arvalid_o && arclass_o == 2'h0 &&
    araddr_o == $past(miss_addr_i); endproperty
  a_fill: assert property (p_fill) else $error("linefill issue wrong");
  property p_ord; ord_ack_o |-> arvalid_o &&
    araddr_o == $past(ord_addr_i) &&
    arclass_o == ($past(ord_dev_i) ? 2'h2 : 2'h1); endproperty
  a_ord: assert property (p_ord) else $error("ordered issue wrong");
  property p_hold; s_stall |=> arvalid_o && $stable(araddr_o); endproperty
  a_hold: assert property (p_hold) else $error("address dropped");
  property p_fair; !prio_en_o && miss_req_i && $past(miss_req_i) &&
    !$past(ord_req_i) && !miss_ack_o |=> !ord_ack_o; endproperty
  a_fair: assert property (p_fair) else $error("younger read won");
  // grants are spaced so one ack never overlaps the next
  property p_space; s_grant |=> !(ord_ack_o || miss_ack_o); endproperty
  a_space: assert property (p_space) else $error("grants too close");
endmodule // l2rpa_arbiter_sva
bind l2rpa_arbiter l2rpa_arbiter_sva #(.NUM_SLOTS(NUM_SLOTS),
  .ADDR_W(ADDR_W)) u_sva (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
  .aux_ctrl_i(aux_ctrl_i), .ord_req_i(ord_req_i), .ord_dev_i(ord_dev_i),
  .ord_addr_i(ord_addr_i), .miss_req_i(miss_req_i),
  .miss_addr_i(miss_addr_i), .ord_ack_o(ord_ack_o),
  .miss_ack_o(miss_ack_o), .arvalid_o(arvalid_o), .araddr_o(araddr_o),
  .arclass_o(arclass_o), .arready_i(arready_i), .prio_en_o(prio_en_o),
  .busy_cnt_o(busy_cnt_o));
`default_nettype wire

/* File: tb/l2rpa_l3_model.sv */
// l2rpa_l3_model.sv - behavioural downstream memory for the arbiter
`default_nettype none
module l2rpa_l3_model (
  // clock and reset
  input  wire logic clk_sys_i,
  input  wire logic rst_i,
  // address channel, completion, stall control
  input  wire logic arvalid_i,
  input  wire logic hold_i,
  output logic      arready_o,
  output logic      rdone_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pend_r;
  // ===========================
  // ready every other cycle so the arbiter must hold its address;
  // a completion only for a read really taken, none while held
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      arready_o <= 1'b0;
      rdone_o   <= 1'b0;
      pend_r    <= 4'h0;
    end else begin
      arready_o <= !arready_o;
      rdone_o   <= !hold_i && pend_r != 4'h0 && !rdone_o;
      pend_r    <= pend_r + 4'(arvalid_i && arready_o) - 4'(rdone_o);
    end
  end
endmodule // l2rpa_l3_model
`default_nettype wire

/* File: tb/l2rpa_arbiter_test.sv */
// l2rpa_arbiter_test.sv - self-checking bench for the read arbiter
`default_nettype none
module l2rpa_arbiter_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i = 1'b0, rst_i = 1'b1, hold = 1'b0;
  logic        ord_req_i = 1'b0, miss_req_i = 1'b0, arready_i, rdone_i;
  logic        ord_dev_i = 1'b0;
  logic [31:0] aux_ctrl_i = 32'h0, araddr_o;
  logic        ord_ack_o, miss_ack_o, arvalid_o, prio_en_o;
  logic [1:0]  arclass_o;
  logic [3:0]  busy_cnt_o;
  int          fails = 0, samples_checked = 0;
  // ===========================
  // clock, design and far side
  always #5 clk_sys_i = ~clk_sys_i;
  l2rpa_arbiter i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .aux_ctrl_i(aux_ctrl_i), .ord_req_i(ord_req_i), .ord_dev_i(ord_dev_i),
    .ord_addr_i(32'h2000), .ord_ack_o(ord_ack_o), .miss_req_i(miss_req_i),
    .miss_addr_i(32'h3000), .miss_ack_o(miss_ack_o), .arvalid_o(arvalid_o),
    .araddr_o(araddr_o), .arclass_o(arclass_o), .arready_i(arready_i),
    .rdone_i(rdone_i), .prio_en_o(prio_en_o), .busy_cnt_o(busy_cnt_o));
  l2rpa_l3_model u_l3 (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
    .arvalid_i(arvalid_o), .hold_i(hold), .arready_o(arready_i),
    .rdone_o(rdone_i));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // bounded wait for any grant, a hang ends the run
  task automatic wgrant;
    int i;
    for (i = 0; i < 40 && !(ord_ack_o || miss_ack_o); i++)
      @(negedge clk_sys_i);
    if (i == 40) begin
      fails++;
      $display("[FAIL] %0t grant wait got %h exp %h", $time, 1'b0, 1'b1);
      test_done();
    end
  endtask
  // fill all slots, queue a miss before an ordered stream, then free
  // the slots: the miss is older, so only priority may pass it
  task automatic t_round(input logic prio);
    int n;
    int m;
    logic [1:0] first;
    aux_ctrl_i = {21'h0, prio, 10'h0};
    hold = 1'b1;
    ord_req_i = 1'b1;
    for (n = 0; n < 4; n++) begin
      ord_dev_i = n[0];
      wgrant();
      chk(32'(arclass_o), ord_dev_i ? 32'h2 : 32'h1);
      ord_req_i = (n != 3);
      @(negedge clk_sys_i);
    end
    repeat (6) @(negedge clk_sys_i);
    chk(32'(busy_cnt_o), 32'h4);
    chk(32'(prio_en_o), 32'(prio));
    miss_req_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    ord_req_i = 1'b1;
    hold = 1'b0;
    m = 0;
    first = 2'h0;
    repeat (24) begin
      @(negedge clk_sys_i);
      if (first == 2'h0) first = {ord_ack_o, miss_ack_o};
      if (miss_ack_o) begin
        m++;
        miss_req_i = 1'b0;
        chk(araddr_o, 32'h3000);
      end
    end
    chk(32'(first), prio ? 32'h2 : 32'h1);
    chk(32'(m), prio ? 32'h0 : 32'h1);
    wgrant();
    ord_req_i = 1'b0;
    @(negedge clk_sys_i);
    if (prio) begin
      wgrant();
      chk(32'(miss_ack_o), 32'h1);
      miss_req_i = 1'b0;
    end
    repeat (20) @(negedge clk_sys_i);
    chk(32'(busy_cnt_o), 32'h0);
  endtask
  // reset in mid-run with the enable bit still set: off at release,
  // then the copy of the bit follows one cycle later
  task automatic t_reset;
    rst_i = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(32'({prio_en_o, arvalid_o, busy_cnt_o}), 32'h0);
    @(negedge clk_sys_i);
    chk(32'(prio_en_o), 32'h1);
  endtask
  initial begin
    repeat (2) @(negedge clk_sys_i);
    rst_i = 1'b0;
    chk(32'({prio_en_o, arvalid_o, busy_cnt_o}), 32'h0);
    t_round(1'b0);
    t_round(1'b1);
    t_reset();
    test_done();
  end
endmodule // l2rpa_arbiter_test
`default_nettype wire
